/* hw/pls_limit_select.sv */
/*
 * Source selection for the current limit and fault AB paths of the
 * second digital PWM channel: two enable masks, their register port,
 * input synchronisation and the gated OR of each selected source set.
 * Assumes a single 100 MHz clock, a synchronous active-low reset and a
 * register master that keeps the strobe rules of the plain port.
 */
// Decided for this implementation: strobed register access.
//
// Overview of operation
// - Mask bit 15 lets the peak-current detector drive the limit.
// - Mask bits 14..11 gate digital comparators 3..0 into the limit.
// - Mask bits 10..7 gate external protection pins 3..0 into the limit.
// - Mask bits 6..0 gate analog comparators G..A into the limit.
// - Both masks reset to zero, so nothing drives limit or fault.
// - Fault AB mask has fifteen enables, same layout, no peak-current bit.
// - Every defined enable bit is read/write and reads back last write.
//
`timescale 1ns/100ps
`default_nettype none

module pls_limit_select (
    input wire logic CLK,
    input wire logic RESET_N,
    input wire logic [31:0] ADDR,
    input wire logic [31:0] WDATA,
    input wire logic WR,
    input wire logic RD,
    output logic [31:0] RDATA,
    input wire logic PEAK_CUR_DET,
    input wire logic [3:0] DIGITAL_CMP,
    input wire logic [3:0] EXT_PROTECT_PIN,
    input wire logic [6:0] ANALOG_CMP,
    output logic CUR_LIMIT,
    output logic FAULT_AB
);

    // ****************************************************************
    // Register selector
    // ****************************************************************
    typedef enum {
        SEL_NONE,
        SEL_CLIM,
        SEL_FAB,
        SEL_STAT
    } pls_sel_e;

    // Decodes a byte address; used by both the write and read paths
    function automatic pls_sel_e decode_addr(input logic [31:0] a);
        pls_sel_e s;
        s = SEL_NONE;
        if (a == pls_pkg::CUR_LIMIT_SOURCE_MASK_ADDR) begin
            s = SEL_CLIM;
        end else if (a == pls_pkg::FAULT_AB_SOURCE_MASK_ADDR) begin
            s = SEL_FAB;
        end else if (a == pls_pkg::SOURCE_STATUS_ADDR) begin
            s = SEL_STAT;
        end
        return s;
    endfunction : decode_addr

    // Places the four source groups into the shared bit layout
    function automatic logic [15:0] pack_sources(
        input logic peak,
        input logic [3:0] dig,
        input logic [3:0] pin,
        input logic [6:0] ana
    );
        logic [15:0] v;
        v = '0;
        v[pls_pkg::PEAK_CUR_BIT] = peak;
        v[pls_pkg::DIG_CMP_LSB +: pls_pkg::DIG_CMP_W] = dig;
        v[pls_pkg::EXT_PIN_LSB +: pls_pkg::EXT_PIN_W] = pin;
        v[pls_pkg::ANA_CMP_LSB +: pls_pkg::ANA_CMP_W] = ana;
        return v;
    endfunction : pack_sources

    // ****************************************************************
    // Declarations
    // ****************************************************************
    logic [15:0] clim_mask_q;
    logic [14:0] fab_mask_q;
    logic clim_seen_q;
    logic fab_seen_q;
    logic [31:0] rdata_q;
    logic peak_sync;
    logic [3:0] pin_sync;
    logic [6:0] ana_sync;
    logic [15:0] src_vec;
    logic [31:0] status_word;
    logic cur_limit_hit;
    logic fault_ab_hit;
    pls_sel_e wr_sel;
    pls_sel_e rd_sel;
    logic clr_clim_seen;
    logic clr_fab_seen;

    // ****************************************************************
    // Input synchronisation
    // ****************************************************************
    // Peak-current detector, pins and analog comparators come from
    // outside this clock; digital comparators are on CLK already, so
    // those reach the gate two cycles sooner than the others.
    pls_sync #(
        .WIDTH(12),
        .STAGES(pls_pkg::SYNC_STAGES)
    ) u_sync (
        .clk(CLK),
        .reset_n(RESET_N),
        .async_in({PEAK_CUR_DET, EXT_PROTECT_PIN, ANALOG_CMP}),
        .sync_q({peak_sync, pin_sync, ana_sync})
    );

    assign src_vec = pack_sources(peak_sync, DIGITAL_CMP, pin_sync,
        ana_sync);

    // ****************************************************************
    // Register writes
    // ****************************************************************
    assign wr_sel = decode_addr(ADDR);
    assign rd_sel = decode_addr(ADDR);

    always_ff @(posedge CLK) begin
        if (!RESET_N) begin
            clim_mask_q <= pls_pkg::CLIM_RESET;
        end else if (WR && wr_sel == SEL_CLIM) begin
            clim_mask_q <= WDATA[pls_pkg::CLIM_W-1:0];
        end
    end

    // fault mask written
    // Bit 15 of the write data is dropped; there is no peak enable here
    always_ff @(posedge CLK) begin
        if (!RESET_N) begin
            fab_mask_q <= pls_pkg::FAB_RESET;
        end else if (WR && wr_sel == SEL_FAB) begin
            fab_mask_q <= WDATA[pls_pkg::FAB_W-1:0];
        end
    end

    // ****************************************************************
    // Sticky event flags
    // ****************************************************************
    // Software clears a flag by writing one to it in the status word;
    // a hit in the same cycle wins so no event is lost.
    assign clr_clim_seen = WR && wr_sel == SEL_STAT &&
        WDATA[pls_pkg::STAT_CLIM_SEEN_BIT];
    assign clr_fab_seen = WR && wr_sel == SEL_STAT &&
        WDATA[pls_pkg::STAT_FAB_SEEN_BIT];

    // Latch current limit events
    always_ff @(posedge CLK) begin
        if (!RESET_N) begin
            clim_seen_q <= 1'b0;
        end else if (cur_limit_hit) begin
            clim_seen_q <= 1'b1;
        end else if (clr_clim_seen) begin
            clim_seen_q <= 1'b0;
        end
    end

    // Latch fault AB events
    always_ff @(posedge CLK) begin
        if (!RESET_N) begin
            fab_seen_q <= 1'b0;
        end else if (fault_ab_hit) begin
            fab_seen_q <= 1'b1;
        end else if (clr_fab_seen) begin
            fab_seen_q <= 1'b0;
        end
    end

    // ****************************************************************
    // Source gating
    // ****************************************************************
    // limit and fault enable gates
    pls_gate_or #(
        .WIDTH(pls_pkg::CLIM_W)
    ) u_clim_gate (
        .clk(CLK),
        .reset_n(RESET_N),
        .mask(clim_mask_q),
        .src(src_vec),
        .hit_q(cur_limit_hit)
    );

    pls_gate_or #(
        .WIDTH(pls_pkg::FAB_W)
    ) u_fab_gate (
        .clk(CLK),
        .reset_n(RESET_N),
        .mask(fab_mask_q),
        .src(src_vec[pls_pkg::FAB_W-1:0]),
        .hit_q(fault_ab_hit)
    );

    assign CUR_LIMIT = cur_limit_hit;
    assign FAULT_AB = fault_ab_hit;

    // ****************************************************************
    // Register reads
    // ****************************************************************
    // Status shows the live sources as the gates see them
    always_comb begin
        status_word = '0;
        status_word[pls_pkg::STAT_SRC_LSB +: 16] = src_vec;
        status_word[pls_pkg::STAT_CLIM_BIT] = cur_limit_hit;
        status_word[pls_pkg::STAT_FAB_BIT] = fault_ab_hit;
        status_word[pls_pkg::STAT_CLIM_SEEN_BIT] = clim_seen_q;
        status_word[pls_pkg::STAT_FAB_SEEN_BIT] = fab_seen_q;
    end

    // read back masks
    // Data stand for the one cycle after the strobe, zero otherwise;
    // unmapped addresses read as zero
    always_ff @(posedge CLK) begin
        if (!RESET_N) begin
            rdata_q <= '0;
        end else if (RD) begin
            case (rd_sel)
                SEL_CLIM: begin
                    rdata_q <= {16'h0000, clim_mask_q};
                end
                SEL_FAB: begin
                    rdata_q <= {17'h00000, fab_mask_q};
                end
                SEL_STAT: begin
                    rdata_q <= status_word;
                end
                default: begin
                    rdata_q <= '0;
                end
            endcase
        end else begin
            rdata_q <= '0;
        end
    end

    assign RDATA = rdata_q;

endmodule : pls_limit_select

`default_nettype wire

/* hw/pls_pkg.sv */
/*
 * Constants shared by the PWM channel 1 limit source selection block:
 * register byte addresses, field positions, reset values and widths.
 * Assumes a 32-bit byte address and 32-bit data on the register port.
 */
package pls_pkg;

    // ****************************************************************
    // Bus widths
    // ****************************************************************
    localparam int ADDR_W = 32;
    localparam int DATA_W = 32;

    // ****************************************************************
    // Register byte addresses
    // ****************************************************************
    localparam logic [31:0] CUR_LIMIT_SOURCE_MASK_ADDR = 32'h0013_0044;
    localparam logic [31:0] FAULT_AB_SOURCE_MASK_ADDR = 32'h0013_0048;
    localparam logic [31:0] SOURCE_STATUS_ADDR = 32'h0013_0060;

    // ****************************************************************
    // Register widths and reset values
    // ****************************************************************
    localparam int CLIM_W = 16;
    localparam int FAB_W = 15;
    localparam logic [15:0] CLIM_RESET = 16'h0000;
    localparam logic [14:0] FAB_RESET = 15'h0000;

    // ****************************************************************
    // Field positions, shared by both masks and the source vector
    // ****************************************************************
    localparam int PEAK_CUR_BIT = 15;
    localparam int DIG_CMP_LSB = 11;
    localparam int DIG_CMP_W = 4;
    localparam int EXT_PIN_LSB = 7;
    localparam int EXT_PIN_W = 4;
    localparam int ANA_CMP_LSB = 0;
    localparam int ANA_CMP_W = 7;

    // ****************************************************************
    // Status register fields
    // ****************************************************************
    localparam int STAT_SRC_LSB = 0;
    localparam int STAT_CLIM_BIT = 16;
    localparam int STAT_FAB_BIT = 17;
    localparam int STAT_CLIM_SEEN_BIT = 18;
    localparam int STAT_FAB_SEEN_BIT = 19;

    // ****************************************************************
    // Synchroniser depth for inputs from outside the clock domain
    // ****************************************************************
    localparam int SYNC_STAGES = 2;

endpackage : pls_pkg

/* hw/pls_sync.sv */
/*
 * Multi-bit level synchroniser, one independent chain per bit.
 * Assumes the inputs are slow levels; bits are not coherent as a word.
 */
`timescale 1ns/100ps
`default_nettype none

module pls_sync #(
    parameter int WIDTH = 1,
    parameter int STAGES = 2
) (
    input wire logic clk,
    input wire logic reset_n,
    input wire logic [WIDTH-1:0] async_in,
    output logic [WIDTH-1:0] sync_q
);

    // ****************************************************************
    // Elaboration checks
    // ****************************************************************
    if (WIDTH < 1) begin : g_bad_width
        $error("pls_sync: WIDTH must be at least 1");
    end
    if (STAGES < 2) begin : g_bad_stages
        $error("pls_sync: STAGES must be at least 2");
    end

    logic [WIDTH-1:0] chain_q [STAGES-1];

    // First stage is read only by the next stage, never by logic
    always_ff @(posedge clk) begin
        if (!reset_n) begin
            for (int i = 0; i < STAGES - 1; i++) begin
                chain_q[i] <= '0;
            end
            sync_q <= '0;
        end else begin
            chain_q[0] <= async_in;
            for (int i = 1; i < STAGES - 1; i++) begin
                chain_q[i] <= chain_q[i-1];
            end
            sync_q <= chain_q[STAGES-2];
        end
    end

endmodule : pls_sync

`default_nettype wire

/* hw/pls_gate_or.sv */
/*
 * Gates a source vector with an enable mask and ORs the survivors into
 * one registered indication. Assumes all inputs are on clk already.
 */
`timescale 1ns/100ps
`default_nettype none

module pls_gate_or #(
    parameter int WIDTH = 16
) (
    input wire logic clk,
    input wire logic reset_n,
    input wire logic [WIDTH-1:0] mask,
    input wire logic [WIDTH-1:0] src,
    output logic hit_q
);

    // ****************************************************************
    // Elaboration check
    // ****************************************************************
    if (WIDTH < 1) begin : g_bad_width
        $error("pls_gate_or: WIDTH must be at least 1");
    end

    // any enabled source
    // Registered so the consumer sees a glitch-free level
    always_ff @(posedge clk) begin
        if (!reset_n) begin
            hit_q <= 1'b0;
        end else begin
            hit_q <= |(mask & src);
        end
    end

endmodule : pls_gate_or

`default_nettype wire

/* verif/pls_limit_select_chk.sv */
/* Port checker for pls_limit_select: register port timing, reset
   state and source gating. Assumes one clock and a synchronous
   active-low reset; bound to the design at the foot of this file. */
`timescale 1ns/100ps
`default_nettype none
module pls_chk (
    input wire logic CLK,
    input wire logic RESET_N,
    input wire logic [31:0] ADDR,
    input wire logic [31:0] WDATA,
    input wire logic WR,
    input wire logic RD,
    input wire logic [31:0] RDATA,
    input wire logic PEAK_CUR_DET,
    input wire logic [3:0] DIGITAL_CMP,
    input wire logic [3:0] EXT_PROTECT_PIN,
    input wire logic [6:0] ANALOG_CMP,
    input wire logic CUR_LIMIT,
    input wire logic FAULT_AB
);
    logic [15:0] clim_q;
    logic [14:0] fab_q;
    logic clim_dig_only;
    logic fab_dig_only;
    logic clim_hit;
    logic fab_hit;

    // Shadow masks; lets read data be judged against the last write
    always_ff @(posedge CLK) begin
        if (!RESET_N) begin
            clim_q <= 16'h0000;
            fab_q <= 15'h0000;
        end else if (WR && ADDR == pls_pkg::CUR_LIMIT_SOURCE_MASK_ADDR) begin
            clim_q <= WDATA[15:0];
        end else if (WR && ADDR == pls_pkg::FAULT_AB_SOURCE_MASK_ADDR) begin
            fab_q <= WDATA[14:0];
        end
    end

    // Only the synchronous comparators enabled: exact one-cycle figure
    assign clim_dig_only = !clim_q[15] && clim_q[10:0] == 11'h000;
    assign fab_dig_only = fab_q[10:0] == 11'h000;
    assign clim_hit = |(DIGITAL_CMP & clim_q[14:11]);
    assign fab_hit = |(DIGITAL_CMP & fab_q[14:11]);

    // ****************************************************************
    // Properties
    // ****************************************************************
    default clocking dcb @(posedge CLK); endclocking
    default disable iff (!RESET_N);

    sequence s_read(a);
        RD && ADDR == a;
    endsequence
    sequence s_peak_held;
        (clim_q == 16'h8000 && PEAK_CUR_DET) [*4];
    endsequence

    property p_rd_idle;
        !RD |=> RDATA == 32'h0;
    endproperty
    a_rd_idle: assert property (p_rd_idle) else $error("read data not idle");
    property p_unmapped;
        RD && ADDR != pls_pkg::CUR_LIMIT_SOURCE_MASK_ADDR
            && ADDR != pls_pkg::FAULT_AB_SOURCE_MASK_ADDR
            && ADDR != pls_pkg::SOURCE_STATUS_ADDR |=> RDATA == 32'h0;
    endproperty
    a_unmapped: assert property (p_unmapped) else $error("unmapped read");
    property p_clim_rd;
        s_read(pls_pkg::CUR_LIMIT_SOURCE_MASK_ADDR) |=>
            RDATA == {16'h0, clim_q};
    endproperty
    a_clim_rd: assert property (p_clim_rd) else $error("limit mask read");
    property p_fab_rd;
        s_read(pls_pkg::FAULT_AB_SOURCE_MASK_ADDR) |=>
            RDATA == {17'h0, fab_q};
    endproperty
    a_fab_rd: assert property (p_fab_rd) else $error("fault mask read");
    property p_reset;
        disable iff (1'b0) !RESET_N |=> RDATA == 32'h0 && !CUR_LIMIT && !FAULT_AB;
    endproperty
    a_reset: assert property (p_reset) else $error("outputs after reset");
    property p_clim_off;
        clim_q == 16'h0000 |=> !CUR_LIMIT;
    endproperty
    a_clim_off: assert property (p_clim_off) else $error("limit unmasked");
    property p_fab_off;
        fab_q == 15'h0000 |=> !FAULT_AB;
    endproperty
    a_fab_off: assert property (p_fab_off) else $error("fault unmasked");
    property p_dig_on;
        clim_dig_only && clim_hit |=> CUR_LIMIT;
    endproperty
    a_dig_on: assert property (p_dig_on) else $error("limit missed");
    property p_fab_dig;
        fab_dig_only |=> FAULT_AB == $past(fab_hit);
    endproperty
    a_fab_dig: assert property (p_fab_dig) else $error("fault gating");
    property p_peak;
        s_peak_held |=> CUR_LIMIT;
    endproperty
    a_peak: assert property (p_peak) else $error("peak limit missed");
endmodule : pls_chk

bind pls_limit_select pls_chk i_chk (.CLK(CLK), .RESET_N(RESET_N),
    .ADDR(ADDR), .WDATA(WDATA), .WR(WR), .RD(RD), .RDATA(RDATA),
    .PEAK_CUR_DET(PEAK_CUR_DET), .DIGITAL_CMP(DIGITAL_CMP),
    .EXT_PROTECT_PIN(EXT_PROTECT_PIN), .ANALOG_CMP(ANALOG_CMP),
    .CUR_LIMIT(CUR_LIMIT), .FAULT_AB(FAULT_AB));
`default_nettype wire

/* verif/tb_top.sv */
/* Self-checking bench for pls_limit_select. Assumes the port
   checker is bound from its own file. */
`timescale 1ns/100ps
`default_nettype none
module tb_top;
    logic clk = 1'b0;
    logic reset_n = 1'b0;
    logic [31:0] addr = 32'h0;
    logic [31:0] wdata = 32'h0;
    logic wr = 1'b0;
    logic rd = 1'b0;
    logic [31:0] rdata;
    logic [15:0] src = 16'h0;
    logic cur_limit;
    logic fault_ab;
    int n_fail = 0;
    int samples_checked = 0;
    localparam logic [31:0] A_CL = pls_pkg::CUR_LIMIT_SOURCE_MASK_ADDR;
    localparam logic [31:0] A_FB = pls_pkg::FAULT_AB_SOURCE_MASK_ADDR;
    localparam logic [31:0] A_ST = pls_pkg::SOURCE_STATUS_ADDR;

    always #5 clk = ~clk;

    // Source vector uses the mask layout, so bit i feeds mask bit i
    pls_limit_select i_dut (.CLK(clk), .RESET_N(reset_n), .ADDR(addr),
        .WDATA(wdata), .WR(wr), .RD(rd), .RDATA(rdata),
        .PEAK_CUR_DET(src[15]), .DIGITAL_CMP(src[14:11]),
        .EXT_PROTECT_PIN(src[10:7]), .ANALOG_CMP(src[6:0]),
        .CUR_LIMIT(cur_limit), .FAULT_AB(fault_ab));

    // ****************************************************************
    // Compare and bus tasks
    // ****************************************************************
    task automatic chk_word(input string what, input logic [31:0] exp,
        input logic [31:0] got);
        samples_checked++;
        if (got !== exp) begin
            n_fail++;
            $display("[ERR] %s expected %h seen %h", what, exp, got);
        end
    endtask : chk_word

    task automatic chk_bit(input string what, input logic exp, input logic got);
        samples_checked++;
        if (got !== exp) begin
            n_fail++;
            $display("[ERR] %s expected %b seen %b", what, exp, got);
        end
    endtask : chk_bit

    task automatic bus_wr(input logic [31:0] a, input logic [31:0] d);
        @(posedge clk);
        wr <= 1'b1;
        addr <= a;
        wdata <= d;
        @(posedge clk);
        wr <= 1'b0;
    endtask : bus_wr

    // Read data stand only in the cycle after the strobe
    task automatic bus_rd(input logic [31:0] a, output logic [31:0] d);
        @(posedge clk);
        rd <= 1'b1;
        addr <= a;
        @(posedge clk);
        rd <= 1'b0;
        #1;
        d = rdata;
    endtask : bus_rd

    task automatic do_reset();
        reset_n <= 1'b0;
        repeat (16) @(posedge clk);
        reset_n <= 1'b1;
    endtask : do_reset

    task automatic t_reset_vals();
        logic [31:0] d;
        bus_rd(A_CL, d);
        chk_word("limit mask", 32'h0, d);
        bus_rd(A_FB, d);
        chk_word("fault mask", 32'h0, d);
        chk_bit("limit idle", 1'b0, cur_limit);
        chk_bit("fault idle", 1'b0, fault_ab);
        $display("test reset values done");
    endtask : t_reset_vals

    // Write then read with no gap; unmapped write must not leak
    task automatic t_rw();
        logic [31:0] d;
        @(posedge clk);
        wr <= 1'b1;
        addr <= A_FB;
        wdata <= 32'hffff_ffff;
        @(posedge clk);
        wr <= 1'b0;
        rd <= 1'b1;
        @(posedge clk);
        rd <= 1'b0;
        #1;
        chk_word("fault readback", 32'h0000_7fff, rdata);
        bus_wr(A_CL, 32'hffff_a5a5);
        bus_rd(A_CL, d);
        chk_word("limit readback", 32'h0000_a5a5, d);
        bus_wr(32'h0013_004c, 32'hffff_ffff);
        bus_rd(32'h0013_004c, d);
        chk_word("unmapped read", 32'h0, d);
        bus_rd(A_CL, d);
        chk_word("limit kept", 32'h0000_a5a5, d);
        $display("test register access done");
    endtask : t_rw

    // Each source alone: enabled must hit, all others enabled must not
    task automatic t_sources();
        for (int i = 0; i < 16; i++) begin
            bus_wr(A_CL, 32'h1 << i);
            bus_wr(A_FB, 32'h1 << i);
            src <= 16'h1 << i;
            repeat (4) @(posedge clk);
            #1;
            chk_bit("limit on", 1'b1, cur_limit);
            chk_bit("fault on", logic'(i != 15), fault_ab);
            bus_wr(A_CL, ~(32'h1 << i));
            bus_wr(A_FB, ~(32'h1 << i));
            @(posedge clk);
            #1;
            chk_bit("limit masked", 1'b0, cur_limit);
            chk_bit("fault masked", 1'b0, fault_ab);
            @(posedge clk);
            src <= 16'h0;
        end
        $display("test source gating done");
    endtask : t_sources

    // Status word: live sources, hits and sticky flags; a hit beats a
    // clear in the same cycle, then zero masks silence an active source
    task automatic t_status();
        logic [31:0] d;
        repeat (4) @(posedge clk);
        bus_wr(A_ST, 32'h000c_0000);
        bus_rd(A_ST, d);
        chk_word("status idle", 32'h0, d);
        @(posedge clk);
        src <= 16'h0001;
        repeat (4) @(posedge clk);
        bus_rd(A_ST, d);
        chk_word("status hit", 32'h000f_0001, d);
        bus_wr(A_ST, 32'h000c_0000);
        bus_rd(A_ST, d);
        chk_word("status kept", 32'h000f_0001, d);
        bus_wr(A_CL, 32'h0);
        bus_wr(A_FB, 32'h0);
        @(posedge clk);
        #1;
        chk_bit("limit cleared", 1'b0, cur_limit);
        chk_bit("fault cleared", 1'b0, fault_ab);
        @(posedge clk);
        src <= 16'h0;
        $display("test status word done");
    endtask : t_status

    task automatic print_verdict();
        $display("checks %0d mismatches %0d", samples_checked, n_fail);
        if (n_fail == 0 && samples_checked > 0) begin
            $display("Regression OK");
        end else begin
            $display("Regression broken");
        end
        $finish;
    endtask : print_verdict

    // Main sequence, ending with a reset in mid-run
    initial begin
        do_reset();
        t_reset_vals();
        t_rw();
        t_sources();
        t_status();
        do_reset();
        t_reset_vals();
        print_verdict();
    end

    // Watchdog: about sixteen times the expected run length
    initial begin
        repeat (5000) @(posedge clk);
        n_fail++;
        print_verdict();
    end
endmodule : tb_top
`default_nettype wire
